//--- tam_fault_queue.sv
// Consecutive-fault counter for one alarm condition.
// Sampled once per finished conversion, on the core clock.
`timescale 1ns/1ps
`default_nettype none
`include "tam_params.svh"
module tam_fault_queue
  import tam_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic sample_i,
  input wire logic cond_i,
  input wire logic [1:0] qlen_i,
  output logic hit_o,
  output logic present_o
);
  logic [1:0] cnt_r;
  logic [1:0] need_w;
  logic [1:0] cnt_nxt;

  // Reserved code 10 behaves as a length of one
  assign need_w = (qlen_i == `TAM_QCODE_3) ? `TAM_QLEN_3 :
                  (qlen_i == `TAM_QCODE_2) ? `TAM_QLEN_2 : `TAM_QLEN_1;
  assign cnt_nxt = (cnt_r == `TAM_QLEN_3) ? cnt_r : cnt_r + 2'd1;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cnt_r <= 2'd0;
      hit_o <= 1'b0;
      present_o <= 1'b0;
    end else if (sample_i) begin
      cnt_r <= cond_i ? cnt_nxt : 2'd0;
      hit_o <= cond_i && (cnt_nxt >= need_w);
      present_o <= cond_i;
    end
  end
endmodule : tam_fault_queue
`default_nettype wire

//--- tam_host.sv
// Two-wire bus host model that reads and programs the alarm registers.
// Paced by the core clock; the device pulls SDA low through sda_oe_i.
`timescale 1ns/1ps
`default_nettype none
`include "tam_params.svh"
module tam_host (
  input wire logic core_clk_i,
  input wire logic sda_oe_i,
  input wire logic sda_dev_i,
  output logic scl_o,
  output logic sda_o
);
  logic drv_r = 1'b1;
  initial scl_o = 1'b1;
  // Pull-up: a released line reads high
  assign sda_o = drv_r & (~sda_oe_i | sda_dev_i);
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask : tick
  // Start, or repeated start from SCL low
  task automatic start();
    tick(6);
    drv_r <= 1'b1;
    tick(6);
    scl_o <= 1'b1;
    tick(6);
    drv_r <= 1'b0;
    tick(6);
    scl_o <= 1'b0;
  endtask : start
  task automatic stop();
    tick(6);
    drv_r <= 1'b0;
    tick(6);
    scl_o <= 1'b1;
    tick(6);
    drv_r <= 1'b1;
    tick(12);
  endtask : stop
  // One bit: 125 ns SCL period, line sampled late in the high phase
  task automatic xbit(input logic b, output logic r);
    tick(6);
    drv_r <= b;
    tick(7);
    scl_o <= 1'b1;
    tick(8);
    r = sda_o;
    tick(4);
    scl_o <= 1'b0;
  endtask : xbit
  // MSB first, ninth bit returns the acknowledge level
  task automatic xbyte(input logic [7:0] d, output logic [7:0] q, output logic ak);
    for (int i = 7; i >= 0; i--) begin
      xbit(d[i], q[i]);
    end
    xbit(1'b1, ak);
  endtask : xbyte
  task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic wd);
    logic [7:0] q;
    logic n;
    start();
    xbyte({`TAM_DEV_ADDR, 1'b0}, q, n);
    xbyte(c, q, n);
    if (wd) begin
      xbyte(d, q, n);
    end
    stop();
  endtask : wr
  // Read byte when wc, else receive byte (also alert response address)
  task automatic rd(input logic [6:0] a, input logic wc, input logic [7:0] c,
                    output logic [7:0] q, output logic ak);
    logic [7:0] d;
    logic n;
    if (wc) begin
      start();
      xbyte({`TAM_DEV_ADDR, 1'b0}, d, n);
      xbyte(c, d, n);
    end
    start();
    xbyte({a, 1'b1}, d, ak);
    xbyte(8'hff, q, n);
    stop();
  endtask : rd
endmodule : tam_host
`default_nettype wire

//--- tam_params.svh
// Register codes, reset values and timing figures of the temperature alarm block.
// Included by every module file; holds definitions only.
`ifndef TAM_PARAMS_SVH
`define TAM_PARAMS_SVH
// Command codes
`define TAM_REG_LTEMP 8'h00
`define TAM_REG_RTEMP 8'h01
`define TAM_REG_STATUS 8'h02
`define TAM_REG_CFG_RD 8'h03
`define TAM_REG_RATE_RD 8'h04
`define TAM_REG_LHI_RD 8'h05
`define TAM_REG_LLO_RD 8'h06
`define TAM_REG_RHI_RD 8'h07
`define TAM_REG_RLO_RD 8'h08
`define TAM_REG_CFG_WR 8'h09
`define TAM_REG_RATE_WR 8'h0a
`define TAM_REG_LHI_WR 8'h0b
`define TAM_REG_LLO_WR 8'h0c
`define TAM_REG_RHI_WR 8'h0d
`define TAM_REG_RLO_WR 8'h0e
`define TAM_CMD_ONESHOT 8'h0f
`define TAM_REG_RFRAC 8'h10
`define TAM_REG_LFRAC 8'h11
`define TAM_REG_ROT 8'h19
`define TAM_REG_LOT 8'h20
`define TAM_REG_HYS 8'h21
`define TAM_REG_QUEUE 8'h22
`define TAM_REG_MFR 8'hfe
`define TAM_REG_REV 8'hff
// Reset values and the remote sense fault code
`define TAM_RST_HI_LIM 8'h55
`define TAM_RST_LO_LIM 8'h00
`define TAM_RST_OT_LIM 8'h55
`define TAM_RST_ROT_ALT 8'h6e
`define TAM_RST_HYS 8'h0a
`define TAM_RST_QUEUE 8'h80
`define TAM_RST_RATE 8'h07
`define TAM_RST_PTR 8'h00
`define TAM_FAULT_CODE 8'h80
// Field positions
`define TAM_CFG_MASK_BIT 7
`define TAM_CFG_STBY_BIT 6
`define TAM_QLEN_MSB 2
`define TAM_QLEN_LSB 1
// Queue length codes and sample counts
`define TAM_QCODE_2 2'b01
`define TAM_QCODE_3 2'b11
`define TAM_QLEN_1 2'd1
`define TAM_QLEN_2 2'd2
`define TAM_QLEN_3 2'd3
// Bus addresses (7 bit)
`define TAM_DEV_ADDR 7'h4c
`define TAM_ARA_ADDR 7'h0c
// Timing: fastest conversion interval and core clock rate
`define TAM_FAST_PERIOD_MS 250
`define TAM_CLK_KHZ 200000
`define TAM_RATE_TOP 3'd6
`endif

//--- tam_pkg.sv
// Types shared by the temperature alarm block.
// Assumes nothing of its surroundings.
package tam_pkg;
  typedef logic [7:0] tam_byte_t;
  typedef enum logic [1:0] {TAM_CV_WAIT = 2'b01, TAM_CV_CONV = 2'b10} tam_cv_e;
  typedef enum logic [4:0] {
    TAM_SB_IDLE = 5'b00001,
    TAM_SB_RX = 5'b00010,
    TAM_SB_ACK = 5'b00100,
    TAM_SB_TX = 5'b01000,
    TAM_SB_MACK = 5'b10000
  } tam_smb_e;
endpackage : tam_pkg

//--- tam_smb_slave.sv
// Two-wire byte-level slave: address match, command, data and read bytes.
// Pins are asynchronous; the core clock oversamples the bus clock.
`timescale 1ns/1ps
`default_nettype none
`include "tam_params.svh"
module tam_smb_slave
  import tam_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic alert_pend_i,
  input wire logic [7:0] rd_byte_i,
  output logic cmd_wr_o,
  output logic dat_wr_o,
  output logic [7:0] wr_byte_o,
  output logic rd_req_o,
  output logic ara_ok_o
);
  logic scl_s1_r, scl_s2_r, scl_d_r, sda_s1_r, sda_s2_r, sda_d_r;
  tam_smb_e st_r;
  logic [2:0] bit_r;
  logic [1:0] idx_r;
  logic [7:0] sh_r, tx_r, byte_w, load_w;
  logic done_r, ack_r, rd_r, ara_r;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      {scl_s1_r, scl_s2_r, scl_d_r, sda_s1_r, sda_s2_r, sda_d_r} <= 6'h3f;
    end else begin
      {scl_s1_r, scl_s2_r, scl_d_r} <= {scl_i, scl_s1_r, scl_s2_r};
      {sda_s1_r, sda_s2_r, sda_d_r} <= {sda_i, sda_s1_r, sda_s2_r};
    end
  end

  wire scl_rise = scl_s2_r & ~scl_d_r;
  wire scl_fall = ~scl_s2_r & scl_d_r;
  wire bus_start = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
  wire bus_stop = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;
  assign byte_w = {sh_r[6:0], sda_s2_r};
  assign load_w = ara_r ? {`TAM_DEV_ADDR, 1'b0} : rd_byte_i;
  assign sda_o = 1'b0;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      st_r <= TAM_SB_IDLE;
      {bit_r, idx_r, sh_r, tx_r} <= 21'h0;
      {done_r, ack_r, rd_r, ara_r, sda_oe_o} <= 5'h0;
      {cmd_wr_o, dat_wr_o, rd_req_o, ara_ok_o} <= 4'h0;
      wr_byte_o <= 8'h00;
    end else begin
      {cmd_wr_o, dat_wr_o, rd_req_o, ara_ok_o} <= 4'h0;
      if (bus_start) begin
        st_r <= TAM_SB_RX;
        {bit_r, idx_r, done_r, sda_oe_o} <= 7'h0;
      end else if (bus_stop) begin
        st_r <= TAM_SB_IDLE;
        sda_oe_o <= 1'b0;
      end else begin
        case (st_r)
          TAM_SB_RX: begin
            if (scl_rise) begin
              sh_r <= byte_w;
              bit_r <= bit_r + 3'd1;
              if (bit_r == 3'd7) begin
                done_r <= 1'b1;
                wr_byte_o <= byte_w;
                if (idx_r == 2'd0) begin
                  rd_r <= byte_w[0];
                  ara_r <= (byte_w[7:1] == `TAM_ARA_ADDR);
                  ack_r <= (byte_w[7:1] == `TAM_DEV_ADDR) ||
                           ((byte_w[7:1] == `TAM_ARA_ADDR) && byte_w[0] && alert_pend_i);
                  rd_req_o <= (byte_w[7:1] == `TAM_DEV_ADDR) && byte_w[0];
                end else begin
                  ack_r <= 1'b1;
                  cmd_wr_o <= (idx_r == 2'd1);
                  dat_wr_o <= (idx_r == 2'd2);
                end
              end
            end else if (scl_fall && done_r) begin
              done_r <= 1'b0;
              sda_oe_o <= ack_r;
              st_r <= ack_r ? TAM_SB_ACK : TAM_SB_IDLE;
            end
          end
          TAM_SB_ACK: begin
            if (scl_fall) begin
              bit_r <= 3'd0;
              if (rd_r) begin
                sda_oe_o <= ~load_w[7];
                tx_r <= {load_w[6:0], 1'b1};
                st_r <= TAM_SB_TX;
              end else begin
                sda_oe_o <= 1'b0;
                idx_r <= (idx_r == 2'd3) ? idx_r : idx_r + 2'd1;
                st_r <= TAM_SB_RX;
              end
            end
          end
          TAM_SB_TX: begin
            if (scl_rise) begin
              bit_r <= bit_r + 3'd1;
              done_r <= (bit_r == 3'd7);
              if (!sda_oe_o && !sda_s2_r) begin
                st_r <= TAM_SB_IDLE;
              end
            end else if (scl_fall) begin
              done_r <= 1'b0;
              sda_oe_o <= done_r ? 1'b0 : ~tx_r[7];
              tx_r <= {tx_r[6:0], 1'b1};
              st_r <= done_r ? TAM_SB_MACK : TAM_SB_TX;
            end
          end
          TAM_SB_MACK: begin
            if (scl_rise) begin
              ara_ok_o <= ara_r;
              st_r <= sda_s2_r ? TAM_SB_IDLE : TAM_SB_ACK;
            end
          end
          default: st_r <= TAM_SB_IDLE;
        endcase
      end
    end
  end
endmodule : tam_smb_slave
`default_nettype wire

//--- tam_top.sv
// Alarm, status and register logic of a two-channel temperature monitor.
// Conversion front end sits on the core clock; bus pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "tam_params.svh"
module tam_top
  import tam_pkg::*;
#(
  parameter logic [31:0] FAST_INTERVAL_CYC = `TAM_FAST_PERIOD_MS * `TAM_CLK_KHZ,
  parameter logic [7:0] MFR_ID = 8'h5a, // Arbitrary value
  parameter logic [7:0] REV_ID = 8'h01 // Arbitrary value
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic rot_alt_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic alert_n_o,
  output logic alert_oe_o,
  output logic overtemp_out_n_o,
  output logic conv_start_o,
  input wire logic conv_done_i,
  input wire logic [7:0] local_temp_i,
  input wire logic [2:0] local_frac_i,
  input wire logic [7:0] remote_temp_i,
  input wire logic [2:0] remote_frac_i,
  input wire logic sense_open_i,
  input wire logic sense_short_i
);
  tam_cv_e cv_r;
  logic [31:0] tmr_r, interval_w;
  logic [2:0] shamt_w;
  logic kick_r, eval_r, alert_latch_r, loc_ot_r, rem_ot_r;
  logic cfg_mask_r, cfg_stby_r, os_go_w, stat_rd_w;
  logic cmd_wr_w, dat_wr_w, rd_req_w, ara_ok_w;
  tam_byte_t wr_byte_w, rd_byte_r, rd_mux_w, ptr_r, rate_r;
  tam_byte_t lhl_r, lll_r, rhl_r, rll_r, lot_lim_r, rot_lim_r, hys_r, queue_r;
  tam_byte_t lt_r, rt_r, rt_w, status_w;
  logic [2:0] lfr_r, rfr_r;
  logic [4:0] cond_w, hit_w, present_w, flags_r;

  // Bus slave
  tam_smb_slave u_smb (
    .core_clk_i(core_clk_i),
    .srst_i(srst_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe_o(sda_oe_o),
    .alert_pend_i(alert_oe_o),
    .rd_byte_i(rd_byte_r),
    .cmd_wr_o(cmd_wr_w),
    .dat_wr_o(dat_wr_w),
    .wr_byte_o(wr_byte_w),
    .rd_req_o(rd_req_w),
    .ara_ok_o(ara_ok_w)
  );

  // Conversion scheduling
  assign shamt_w = (rate_r[2:0] >= `TAM_RATE_TOP) ? 3'd0 : `TAM_RATE_TOP - rate_r[2:0];
  assign interval_w = FAST_INTERVAL_CYC << shamt_w;
  assign os_go_w = cmd_wr_w && (wr_byte_w == `TAM_CMD_ONESHOT) && (cv_r == TAM_CV_WAIT);

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cv_r <= TAM_CV_WAIT;
      tmr_r <= 32'd0;
      kick_r <= 1'b1;
      conv_start_o <= 1'b0;
    end else begin
      conv_start_o <= 1'b0;
      tmr_r <= cfg_stby_r ? 32'd0 : tmr_r + 32'd1;
      case (cv_r)
        TAM_CV_WAIT: begin
          if (kick_r || os_go_w || (!cfg_stby_r && tmr_r >= interval_w - 32'd1)) begin
            cv_r <= TAM_CV_CONV;
            conv_start_o <= 1'b1;
            tmr_r <= 32'd0;
            kick_r <= 1'b0;
          end
        end
        TAM_CV_CONV: begin
          if (conv_done_i) begin
            cv_r <= TAM_CV_WAIT;
          end
        end
        default: cv_r <= TAM_CV_WAIT;
      endcase
    end
  end

  // Result capture and limit comparison
  assign rt_w = (sense_open_i || sense_short_i) ? `TAM_FAULT_CODE : remote_temp_i;
  assign cond_w = {local_temp_i >= lhl_r, local_temp_i < lll_r,
                   rt_w >= rhl_r, rt_w < rll_r, sense_open_i};

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      {lt_r, rt_r} <= 16'h0;
      {lfr_r, rfr_r} <= 6'h0;
      eval_r <= 1'b0;
    end else begin
      eval_r <= conv_done_i && (cv_r == TAM_CV_CONV);
      if (conv_done_i && (cv_r == TAM_CV_CONV)) begin
        lt_r <= local_temp_i;
        lfr_r <= local_frac_i;
        rt_r <= rt_w;
        rfr_r <= (sense_open_i || sense_short_i) ? 3'd0 : remote_frac_i;
      end
    end
  end

  // One queue per alert condition
  for (genvar gi = 0; gi < 5; gi++) begin : g_queue
    tam_fault_queue u_fq (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .sample_i(conv_done_i && (cv_r == TAM_CV_CONV)),
      .cond_i(cond_w[gi]),
      .qlen_i(queue_r[`TAM_QLEN_MSB:`TAM_QLEN_LSB]),
      .hit_o(hit_w[gi]),
      .present_o(present_w[gi])
    );
  end

  // Status flags and interrupt latch; a set beats a clear
  assign stat_rd_w = rd_req_w && (ptr_r == `TAM_REG_STATUS);

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      flags_r <= 5'h0;
      alert_latch_r <= 1'b0;
      alert_oe_o <= 1'b0;
    end else begin
      flags_r <= (flags_r & ~(stat_rd_w ? ~present_w : 5'h0)) |
                 (eval_r ? hit_w : 5'h0);
      if (eval_r && |hit_w) begin
        alert_latch_r <= 1'b1;
      end else if ((stat_rd_w || ara_ok_w) && !(|present_w)) begin
        alert_latch_r <= 1'b0;
      end
      alert_oe_o <= alert_latch_r && !cfg_mask_r;
    end
  end
  assign alert_n_o = 1'b0;

  // Overtemperature with hysteresis
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      loc_ot_r <= 1'b0;
      rem_ot_r <= 1'b0;
    end else if (eval_r) begin
      if (lt_r >= lot_lim_r) begin
        loc_ot_r <= 1'b1;
      end else if ({1'b0, lt_r} + {1'b0, hys_r} < {1'b0, lot_lim_r}) begin
        loc_ot_r <= 1'b0;
      end
      if (rt_r >= rot_lim_r) begin
        rem_ot_r <= 1'b1;
      end else if ({1'b0, rt_r} + {1'b0, hys_r} < {1'b0, rot_lim_r}) begin
        rem_ot_r <= 1'b0;
      end
    end
  end
  assign overtemp_out_n_o = !(loc_ot_r || rem_ot_r);

  // Register writes and command pointer
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      ptr_r <= `TAM_RST_PTR;
      {cfg_mask_r, cfg_stby_r} <= 2'b00;
      rate_r <= `TAM_RST_RATE;
      {lhl_r, rhl_r} <= {`TAM_RST_HI_LIM, `TAM_RST_HI_LIM};
      {lll_r, rll_r} <= {`TAM_RST_LO_LIM, `TAM_RST_LO_LIM};
      {lot_lim_r, rot_lim_r} <= {`TAM_RST_OT_LIM, `TAM_RST_OT_LIM};
      hys_r <= `TAM_RST_HYS;
      queue_r <= `TAM_RST_QUEUE;
    end else begin
      if (cmd_wr_w) begin
        ptr_r <= wr_byte_w;
      end
      // Strap taken in the first cycle after reset, while the power-up kick stands
      if (kick_r && rot_alt_i) begin
        rot_lim_r <= `TAM_RST_ROT_ALT;
      end
      if (dat_wr_w) begin
        case (ptr_r)
          `TAM_REG_CFG_WR: begin
            cfg_mask_r <= wr_byte_w[`TAM_CFG_MASK_BIT];
            cfg_stby_r <= wr_byte_w[`TAM_CFG_STBY_BIT];
          end
          `TAM_REG_RATE_WR: rate_r <= wr_byte_w;
          `TAM_REG_LHI_WR: lhl_r <= wr_byte_w;
          `TAM_REG_LLO_WR: lll_r <= wr_byte_w;
          `TAM_REG_RHI_WR: rhl_r <= wr_byte_w;
          `TAM_REG_RLO_WR: rll_r <= wr_byte_w;
          `TAM_REG_ROT: rot_lim_r <= wr_byte_w;
          `TAM_REG_LOT: lot_lim_r <= wr_byte_w;
          `TAM_REG_HYS: hys_r <= wr_byte_w;
          `TAM_REG_QUEUE: queue_r <= wr_byte_w;
          default: ;
        endcase
      end
    end
  end

  // Read path
  assign status_w = {cv_r == TAM_CV_CONV, flags_r, rem_ot_r, loc_ot_r};

  always_comb begin
    case (ptr_r)
      `TAM_REG_LTEMP: rd_mux_w = lt_r;
      `TAM_REG_RTEMP: rd_mux_w = rt_r;
      `TAM_REG_STATUS: rd_mux_w = status_w;
      `TAM_REG_CFG_RD: rd_mux_w = {cfg_mask_r, cfg_stby_r, 6'h00};
      `TAM_REG_RATE_RD: rd_mux_w = rate_r;
      `TAM_REG_LHI_RD: rd_mux_w = lhl_r;
      `TAM_REG_LLO_RD: rd_mux_w = lll_r;
      `TAM_REG_RHI_RD: rd_mux_w = rhl_r;
      `TAM_REG_RLO_RD: rd_mux_w = rll_r;
      `TAM_REG_RFRAC: rd_mux_w = {rfr_r, 5'h00};
      `TAM_REG_LFRAC: rd_mux_w = {lfr_r, 5'h00};
      `TAM_REG_ROT: rd_mux_w = rot_lim_r;
      `TAM_REG_LOT: rd_mux_w = lot_lim_r;
      `TAM_REG_HYS: rd_mux_w = hys_r;
      `TAM_REG_QUEUE: rd_mux_w = queue_r;
      `TAM_REG_MFR: rd_mux_w = MFR_ID;
      `TAM_REG_REV: rd_mux_w = REV_ID;
      default: rd_mux_w = 8'h00;
    endcase
  end

  // Snapshot at the address byte, stable for the whole read
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rd_byte_r <= 8'h00;
    end else if (rd_req_w) begin
      rd_byte_r <= rd_mux_w;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);

  sequence s_os_accept;
    cmd_wr_w && (wr_byte_w == `TAM_CMD_ONESHOT) && (cv_r == TAM_CV_WAIT);
  endsequence
  sequence s_conv_begun;
    conv_start_o && (cv_r == TAM_CV_CONV) && (tmr_r == 32'd0);
  endsequence

  property p_oneshot_start;
    s_os_accept |=> s_conv_begun;
  endproperty
  a_oneshot_start: assert property (p_oneshot_start) else $error("one-shot did not start");
  property p_oneshot_ignore;
    cmd_wr_w && (wr_byte_w == `TAM_CMD_ONESHOT) && (cv_r == TAM_CV_CONV) |=> !conv_start_o;
  endproperty
  a_oneshot_ignore: assert property (p_oneshot_ignore) else $error("one-shot not ignored");
  property p_alert_set;
    eval_r && |hit_w |=> alert_latch_r ##1 (alert_oe_o == !$past(cfg_mask_r));
  endproperty
  a_alert_set: assert property (p_alert_set) else $error("interrupt not raised");
  property p_alert_hold;
    alert_latch_r && |present_w |=> alert_latch_r;
  endproperty
  a_alert_hold: assert property (p_alert_hold) else $error("latch released early");
  property p_mask;
    cfg_mask_r |=> !alert_oe_o;
  endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt driven");
  property p_ot_set;
    eval_r && (rt_r >= rot_lim_r) |=> rem_ot_r && !overtemp_out_n_o;
  endproperty
  a_ot_set: assert property (p_ot_set) else $error("overtemp not asserted");
  property p_ot_hold;
    eval_r && loc_ot_r && ({1'b0, lt_r} + {1'b0, hys_r} >= {1'b0, lot_lim_r}) |=> loc_ot_r;
  endproperty
  a_ot_hold: assert property (p_ot_hold) else $error("overtemp released early");
  property p_fault_code;
    conv_done_i && (cv_r == TAM_CV_CONV) && (sense_open_i || sense_short_i)
      |=> (rt_r == `TAM_FAULT_CODE);
  endproperty
  a_fault_code: assert property (p_fault_code) else $error("fault code not loaded");
  property p_open_flag;
    conv_done_i && (cv_r == TAM_CV_CONV) && sense_open_i && (queue_r[2:1] == 2'b00)
      |=> ##1 flags_r[0] && alert_latch_r;
  endproperty
  a_open_flag: assert property (p_open_flag) else $error("open fault not flagged");
  property p_por;
    $fell(srst_i) |-> (ptr_r == 8'h00) && (lhl_r == 8'h55) && (rll_r == 8'h00)
      && (rate_r == 8'h07) && (hys_r == 8'h0a) && (flags_r == 5'h0);
  endproperty
  a_por: assert property (p_por) else $error("reset values wrong");
  property p_strap;
    kick_r && rot_alt_i && !dat_wr_w |=> (rot_lim_r == `TAM_RST_ROT_ALT);
  endproperty
  a_strap: assert property (p_strap) else $error("strap reset value not applied");
  property p_standby_hold;
    cfg_stby_r && (cv_r == TAM_CV_WAIT) && !kick_r && !os_go_w |=> !conv_start_o;
  endproperty
  a_standby_hold: assert property (p_standby_hold) else $error("standby conversion began");
  property p_standby_timer;
    cfg_stby_r |=> (tmr_r == 32'd0);
  endproperty
  a_standby_timer: assert property (p_standby_timer) else $error("rate timer ran");
  property p_flag_clear;
    stat_rd_w && !eval_r |=> ((flags_r & ~$past(present_w)) == 5'h0);
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("ended flag kept");
  property p_latch_clear;
    (stat_rd_w || ara_ok_w) && !eval_r && !(|present_w) |=> !alert_latch_r;
  endproperty
  a_latch_clear: assert property (p_latch_clear) else $error("interrupt latch kept");
  property p_ot_release;
    eval_r && ({1'b0, lt_r} + {1'b0, hys_r} < {1'b0, lot_lim_r}) |=> !loc_ot_r;
  endproperty
  a_ot_release: assert property (p_ot_release) else $error("overtemp not released");
endmodule : tam_top
`default_nettype wire

//--- test_temp_alarm_register_logic.sv
// Self-checking bench of the temperature alarm block with a bus host model.
// Front end answers each start one cycle later with the bench temperatures.
`timescale 1ns/1ps
`default_nettype none
`include "tam_params.svh"
module test_temp_alarm_register_logic;
  import tam_pkg::*;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic conv_done_i = 1'b0;
  logic sense_open_i = 1'b0;
  logic [7:0] lt = 8'h19;
  logic [7:0] rt = 8'h19;
  logic scl, sda, sda_oe, alert_oe, ot_n, conv_start, ak;
  logic sda_dev, alert_n, sh = 1'b0, rot_alt = 1'b0;
  logic [2:0] lf = 3'h0, rf = 3'h0;
  wire alert_ln = ~alert_oe | alert_n;
  logic [7:0] q;
  logic al = 1'b0, mask = 1'b0, ot_l = 1'b0, ot_r = 1'b0;
  int fail_count = 0, total_checks = 0, seed = 32'ha645, nstart = 0, n0;
  int lim[4] = '{'h55, 0, 'h55, 0};
  logic [15:0] rv[13] = '{16'h0300, 16'h0407, 16'h0555, 16'h0600, 16'h0755, 16'h0800,
                          16'h1955, 16'h2055, 16'h210a, 16'h2280, 16'h3000, 16'hfe5a,
                          16'hff01};
  tam_top #(.FAST_INTERVAL_CYC(32'd200)) i_dut (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .rot_alt_i(rot_alt), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_dev), .sda_oe_o(sda_oe), .alert_n_o(alert_n), .alert_oe_o(alert_oe),
    .overtemp_out_n_o(ot_n), .conv_start_o(conv_start), .conv_done_i(conv_done_i),
    .local_temp_i(lt), .local_frac_i(lf), .remote_temp_i(rt), .remote_frac_i(rf),
    .sense_open_i(sense_open_i), .sense_short_i(sh));
  tam_host i_host (.core_clk_i(core_clk_i), .sda_oe_i(sda_oe), .sda_dev_i(sda_dev),
                   .scl_o(scl), .sda_o(sda));
  initial forever #2.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    conv_done_i <= conv_start;
    nstart <= nstart + int'(conv_start);
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic rreg(input logic [7:0] c, output logic [7:0] v);
    i_host.rd(`TAM_DEV_ADDR, 1'b1, c, v, ak);
  endtask : rreg
  // Apply readings, let conversions run, then compare alarms and registers
  // f[0] opens the remote sense pair, f[1] shorts it
  task automatic step(input logic [7:0] l, input logic [7:0] r, input logic [1:0] f);
    logic [7:0] e, rr;
    lt <= l;
    rt <= r;
    sense_open_i <= f[0];
    sh <= f[1];
    i_host.tick(450);
    rr = (|f) ? 8'h80 : r;
    e = {1'b0, l >= lim[0], l < lim[1], rr >= lim[2], rr < lim[3], f[0], 2'b00};
    al = al | (|e);
    ot_l = (l >= 8'h55) | (ot_l & (l >= 8'h4b));
    ot_r = (rr >= 8'h55) | (ot_r & (rr >= 8'h4b));
    check({7'h0, ot_n}, {7'h0, !(ot_l | ot_r)});
    check({7'h0, alert_ln}, {7'h0, !(al & !mask)});
    i_host.rd(`TAM_ARA_ADDR, 1'b0, 8'h00, q, ak);
    check({7'h0, ak}, {7'h0, !(al & !mask)});
    if (al && !mask) check(q, {`TAM_DEV_ADDR, 1'b0});
    if (!mask) al = al & (|e);
    rreg(`TAM_REG_STATUS, q);
    al = al & (|e);
    rreg(`TAM_REG_STATUS, q);
    check(q & 8'h7c, e);
    check({7'h0, alert_ln}, {7'h0, !(al & !mask)});
    rreg(`TAM_REG_RTEMP, q);
    check(q, rr);
    $display("step %h %h %b done", l, r, f);
  endtask : step
  initial begin
    repeat (100000) @(posedge core_clk_i);
    fail_count++;
    summarize();
  end
  initial begin
    repeat (20) @(posedge core_clk_i);
    srst_i <= 1'b0;
    i_host.tick(10);
    i_host.rd(`TAM_DEV_ADDR, 1'b0, 8'h00, q, ak);
    check(q, 8'h19);
    foreach (rv[i]) begin
      rreg(rv[i][15:8], q);
      check(q, rv[i][7:0]);
    end
    step(8'h19, 8'h19, 2'b00);
    step(8'h55, 8'h20, 2'b00);
    step(8'h4c, 8'h20, 2'b00);
    step(8'h4a, 8'h20, 2'b00);
    step(8'h20, 8'h30, 2'b01);
    step(8'h20, 8'h30, 2'b10);
    step(8'h3f, 8'h3f, 2'b00);
    for (int i = 0; i < 4; i++) begin
      lim[i] = (i % 2) ? ($random(seed) & 'h3f) : ('h40 | ($random(seed) & 'h3f));
      i_host.wr(8'h0b + 8'(i), 8'(lim[i]), 1'b1);
      rreg(8'h05 + 8'(i), q);
      check(q, 8'(lim[i]));
    end
    repeat (4) step(8'($random(seed) & 'h7f), 8'($random(seed) & 'h7f), 2'b00);
    lf <= 3'($random(seed));
    rf <= 3'($random(seed));
    i_host.tick(450);
    rreg(`TAM_REG_LFRAC, q);
    check(q, {lf, 5'h00});
    rreg(`TAM_REG_RFRAC, q);
    check(q, {rf, 5'h00});
    mask = 1'b1;
    i_host.wr(`TAM_REG_CFG_WR, 8'h80, 1'b1);
    step(8'h20, 8'h30, 2'b01);
    rreg(`TAM_REG_CFG_RD, q);
    check(q, 8'h80);
    i_host.wr(`TAM_REG_CFG_WR, 8'hc0, 1'b1);
    i_host.tick(20);
    n0 = nstart;
    i_host.tick(1000);
    check(8'(nstart - n0), 8'h00);
    i_host.wr(`TAM_CMD_ONESHOT, 8'h00, 1'b0);
    i_host.tick(1000);
    check(8'(nstart - n0), 8'h01);
    // Second reset with the strap high
    rot_alt <= 1'b1;
    srst_i <= 1'b1;
    i_host.tick(20);
    srst_i <= 1'b0;
    i_host.tick(10);
    rreg(`TAM_REG_ROT, q);
    check(q, `TAM_RST_ROT_ALT);
    summarize();
  end
endmodule : test_temp_alarm_register_logic
`default_nettype wire
